// ---- seg_lcd_defs.vh ----
// Register map, field layout and timing codes of the segment display timing block
`ifndef SEG_LCD_DEFS_VH
`define SEG_LCD_DEFS_VH

`define REG_IDX_CTRL 8'h4E
`define REG_IDX_CLK 8'h4F
`define REG_IDX_STAT 8'h50
`define REG_IDX_DATA_FIRST 8'h52
`define REG_IDX_DATA_LAST 8'h5F
`define DATA_REG_COUNT 14

`define CTRL_EN 7
`define CTRL_QC 6
`define CTRL_WK 5
`define CTRL_CON_HI 3
`define CTRL_CON_LO 0
`define CTRL_RESET 8'h00
`define CTRL_MASK 8'hEF

`define CLK_QCL_HI 6
`define CLK_QCL_LO 5
`define CLK_DUTY_HI 4
`define CLK_DUTY_LO 3
`define CLK_SEL_HI 2
`define CLK_SEL_LO 0
`define CLK_RESET 8'h00
`define CLK_MASK 8'h7F

`define DUTY_STATIC 2'h0
`define DUTY_THIRD 2'h1
`define DUTY_QUARTER 2'h2
`define DUTY_RSVD 2'h3
`define QCL_RSVD 2'h3
`define SEL_RSVD 3'h7

`define PHASE_LAST_STATIC 2'h0
`define PHASE_LAST_THIRD 2'h2
`define PHASE_LAST_QUARTER 2'h3
`define SHARED_BP_PHASE 2'h3

`define QC_SHIFT_BASE 5'h05
`define ONE_HALF_SHIFT 5'h01

`endif

// ---- plane_divider.v ----
// Base clock divider and fast charge pulse timer
`timescale 1ns/100ps
`include "seg_lcd_defs.vh"

module plane_divider
(
  input wire clk_i,
  input wire rst_i,
  input wire run_i,
  input wire xtal_tick_i,
  input wire [2:0] ratio_sel_i,
  input wire [1:0] charge_len_i,
  output wire half_end_o,
  output wire period_end_o,
  output wire base_clk_o,
  output wire charge_pulse_o
);

  reg [15:0] cnt_q;
  reg base_q;
  wire [4:0] shift;
  wire [15:0] half_last;
  wire [15:0] charge_ticks;

  // Log2 of the divide ratio
  function [4:0] ratio_shift;
    input [2:0] sel;
    begin
      case (sel)
        3'h0: ratio_shift = 5'h07;
        3'h1: ratio_shift = 5'h08;
        3'h2: ratio_shift = 5'h09;
        3'h3: ratio_shift = 5'h0A;
        3'h4: ratio_shift = 5'h0E;
        3'h5: ratio_shift = 5'h0F;
        default: ratio_shift = 5'h10;
      endcase
    end
  endfunction

  assign shift = ratio_shift(ratio_sel_i);
  assign half_last = (16'h0001 << (shift - `ONE_HALF_SHIFT)) - 16'h0001;
  assign charge_ticks = 16'h0001 << (shift - `QC_SHIFT_BASE - {3'h0, charge_len_i});
  assign half_end_o = run_i & xtal_tick_i & (cnt_q == half_last);
  assign period_end_o = half_end_o & base_q;
  assign base_clk_o = base_q;
  assign charge_pulse_o = run_i & (cnt_q < charge_ticks);

  always @(posedge clk_i)
  begin
    if (rst_i || !run_i)
    begin
      cnt_q <= 16'h0000;
      base_q <= 1'b0;
    end
    else if (xtal_tick_i)
    begin
      if (cnt_q == half_last)
      begin
        cnt_q <= 16'h0000;
        base_q <= ~base_q;
      end
      else
      begin
        cnt_q <= cnt_q + 16'h0001;
      end
    end
  end

endmodule

// ---- seg_lcd_timing.v ----
// Segment display control and timing: Wishbone registers, duty sequencing, ladder control
//
// Our own choice: register access over Wishbone.
`timescale 1ns/100ps
`include "seg_lcd_defs.vh"

module seg_lcd_timing
(
  input wire clk_i,
  input wire rst_i,
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [31:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  output wire [31:0] dat_o,
  output wire ack_o,
  input wire crystal_ref_clock,
  output wire [2:0] backplane_out_o,
  output wire [26:1] frontplane_out_o,
  output wire shared_plane_pin_o,
  output wire shared_pin_is_backplane_o,
  output wire plane_polarity_o,
  output wire segment_base_clock_o,
  output wire ladder_weak_o,
  output wire ladder_fast_o,
  output wire [3:0] contrast_code_o,
  output wire [8:0] bias_tenths_o
);

  reg [7:0] ctrl_q;
  reg [7:0] clk_cfg_q;
  reg [7:0] seg_data_q [0:`DATA_REG_COUNT-1];
  reg ack_q;
  reg [7:0] rdata_q;
  reg xtal_s1_q;
  reg xtal_s2_q;
  reg xtal_s3_q;
  reg run_q;
  reg [1:0] duty_act_q;
  reg [2:0] sel_act_q;
  reg [1:0] phase_q;
  reg [2:0] bp_q;
  reg [26:1] fp_q;
  reg shared_q;
  reg shared_bp_q;
  reg polarity_q;
  reg base_q;
  reg weak_q;
  reg fast_q;
  reg [3:0] contrast_q;
  reg [8:0] bias_q;

  wire [7:0] idx;
  wire req;
  wire wr;
  wire is_data;
  wire [3:0] data_slot;
  wire xtal_tick;
  wire run_d;
  wire half_end;
  wire period_end;
  wire base_clk;
  wire charge_pulse;
  wire frame_end;
  wire [1:0] phase_last;
  wire ladder_weak_d;
  wire ladder_fast_d;
  integer f;

  // Last backplane phase of a frame for a duty code
  function [1:0] last_phase;
    input [1:0] duty;
    begin
      case (duty)
        `DUTY_THIRD: last_phase = `PHASE_LAST_THIRD;
        `DUTY_QUARTER: last_phase = `PHASE_LAST_QUARTER;
        default: last_phase = `PHASE_LAST_STATIC;
      endcase
    end
  endfunction

  // Bias level in tenths of a percent of supply
  function [8:0] bias_of;
    input [3:0] code;
    begin
      case (code)
        4'h0: bias_of = 9'h006;
        4'h1: bias_of = 9'h01D;
        4'h2: bias_of = 9'h034;
        4'h3: bias_of = 9'h04A;
        4'h4: bias_of = 9'h060;
        4'h5: bias_of = 9'h074;
        4'h6: bias_of = 9'h087;
        4'h7: bias_of = 9'h099;
        4'h8: bias_of = 9'h0AC;
        4'h9: bias_of = 9'h0BC;
        4'hA: bias_of = 9'h0CD;
        4'hB: bias_of = 9'h0DC;
        4'hC: bias_of = 9'h0EC;
        4'hD: bias_of = 9'h0FA;
        4'hE: bias_of = 9'h108;
        default: bias_of = 9'h115;
      endcase
    end
  endfunction

  // Segment bit for frontplane f and backplane b
  function seg_bit;
    input [7:0] data;
    input fp_odd;
    input [1:0] bp;
    begin
      seg_bit = data[{fp_odd, bp}];
    end
  endfunction

  assign idx = adr_i[9:2];
  assign req = cyc_i & stb_i & ~ack_q;
  assign wr = req & we_i & sel_i[0];
  assign is_data = (idx >= `REG_IDX_DATA_FIRST) && (idx <= `REG_IDX_DATA_LAST);
  assign data_slot = idx[3:0] - 4'h2;

  // Wishbone slave: one wait state, unmapped reads zero
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_q <= 1'b0;
      rdata_q <= 8'h00;
    end
    else
    begin
      ack_q <= req;
      if (req)
      begin
        if (idx == `REG_IDX_CTRL)
          rdata_q <= ctrl_q;
        else if (idx == `REG_IDX_CLK)
          rdata_q <= clk_cfg_q;
        else if (idx == `REG_IDX_STAT)
          rdata_q <= {2'h0, phase_q, sel_act_q[0], duty_act_q, run_q};
        else if (is_data)
          rdata_q <= seg_data_q[data_slot];
        else
          rdata_q <= 8'h00;
      end
    end
  end

  assign dat_o = {24'h000000, rdata_q};
  assign ack_o = ack_q;

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_q <= `CTRL_RESET;
      clk_cfg_q <= `CLK_RESET;
    end
    else if (wr)
    begin
      if (idx == `REG_IDX_CTRL)
        ctrl_q <= dat_i[7:0] & `CTRL_MASK;
      if (idx == `REG_IDX_CLK)
        clk_cfg_q <= dat_i[7:0] & `CLK_MASK;
    end
  end

  // Data registers keep contents across reset
  always @(posedge clk_i)
  begin
    if (wr && is_data)
      seg_data_q[data_slot] <= dat_i[7:0];
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      xtal_s1_q <= 1'b0;
      xtal_s2_q <= 1'b0;
      xtal_s3_q <= 1'b0;
    end
    else
    begin
      xtal_s1_q <= crystal_ref_clock;
      xtal_s2_q <= xtal_s1_q;
      xtal_s3_q <= xtal_s2_q;
    end
  end

  assign xtal_tick = xtal_s2_q & ~xtal_s3_q;

  assign run_d = ctrl_q[`CTRL_EN]
    && (clk_cfg_q[`CLK_QCL_HI:`CLK_QCL_LO] != `QCL_RSVD)
    && (clk_cfg_q[`CLK_DUTY_HI:`CLK_DUTY_LO] != `DUTY_RSVD)
    && (clk_cfg_q[`CLK_SEL_HI:`CLK_SEL_LO] != `SEL_RSVD);

  plane_divider u_div
  (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(run_q),
    .xtal_tick_i(xtal_tick),
    .ratio_sel_i(sel_act_q),
    .charge_len_i(clk_cfg_q[`CLK_QCL_HI:`CLK_QCL_LO]),
    .half_end_o(half_end),
    .period_end_o(period_end),
    .base_clk_o(base_clk),
    .charge_pulse_o(charge_pulse)
  );

  assign phase_last = last_phase(duty_act_q);
  // frame of one period per backplane
  assign frame_end = period_end && (phase_q == phase_last);

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      run_q <= 1'b0;
      duty_act_q <= `DUTY_STATIC;
      sel_act_q <= 3'h0;
      phase_q <= 2'h0;
    end
    else
    begin
      run_q <= run_d;
      if (!run_q || frame_end)
      begin
        duty_act_q <= clk_cfg_q[`CLK_DUTY_HI:`CLK_DUTY_LO];
        sel_act_q <= clk_cfg_q[`CLK_SEL_HI:`CLK_SEL_LO];
        phase_q <= 2'h0;
      end
      else if (period_end)
      begin
        phase_q <= phase_q + 2'h1;
      end
    end
  end

  assign ladder_fast_d = ctrl_q[`CTRL_QC] & ctrl_q[`CTRL_WK] & charge_pulse;
  assign ladder_weak_d = ctrl_q[`CTRL_WK] & ~ladder_fast_d;

  always @(posedge clk_i)
  begin
    if (rst_i || !run_q)
    begin
      bp_q <= 3'h0;
      fp_q <= 26'h0000000;
      shared_q <= 1'b0;
      shared_bp_q <= 1'b0;
      polarity_q <= 1'b0;
      base_q <= 1'b0;
    end
    else
    begin
      base_q <= base_clk;
      polarity_q <= base_clk;
      bp_q <= 3'h1 << phase_q;
      for (f = 1; f <= 26; f = f + 1)
        fp_q[f] <= seg_bit(seg_data_q[f / 2], f[0], phase_q);
      shared_bp_q <= (duty_act_q == `DUTY_QUARTER);
      if (duty_act_q == `DUTY_QUARTER)
        shared_q <= (phase_q == `SHARED_BP_PHASE);
      else
        shared_q <= seg_bit(seg_data_q[0], 1'b0, phase_q);
    end
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      weak_q <= 1'b0;
      fast_q <= 1'b0;
      contrast_q <= 4'h0;
      bias_q <= 9'h006;
    end
    else
    begin
      weak_q <= ladder_weak_d;
      fast_q <= ladder_fast_d;
      contrast_q <= ctrl_q[`CTRL_CON_HI:`CTRL_CON_LO];
      bias_q <= bias_of(ctrl_q[`CTRL_CON_HI:`CTRL_CON_LO]);
    end
  end

  assign backplane_out_o = bp_q;
  assign frontplane_out_o = fp_q;
  assign shared_plane_pin_o = shared_q;
  assign shared_pin_is_backplane_o = shared_bp_q;
  assign plane_polarity_o = polarity_q;
  assign segment_base_clock_o = base_q;
  assign ladder_weak_o = weak_q;
  assign ladder_fast_o = fast_q;
  assign contrast_code_o = contrast_q;
  assign bias_tenths_o = bias_q;

endmodule

// ---- seg_lcd_timing_asserts.sv ----
// Port-level checks for the segment display timing block
`timescale 1ns/100ps
module seg_lcd_timing_asserts
(
  input wire clk_i,
  input wire rst_i,
  input wire cyc_i,
  input wire stb_i,
  input wire [31:0] dat_o,
  input wire ack_o,
  input wire [2:0] backplane_out_o,
  input wire shared_plane_pin_o,
  input wire shared_pin_is_backplane_o,
  input wire segment_base_clock_o,
  input wire ladder_weak_o,
  input wire ladder_fast_o,
  input wire [3:0] contrast_code_o,
  input wire [8:0] bias_tenths_o
);
  localparam logic [8:0] bias_lut [16] = '{6, 29, 52, 74, 96, 116, 135, 153, 172, 188, 205, 220, 236, 250, 264, 277};
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence bus_req;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence ack_pulse;
    ack_o ##1 !ack_o;
  endsequence
  a_ack_one_cycle: assert property (bus_req |=> ack_pulse) else $error("ack not a one-cycle answer");
  a_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i)) else $error("ack without request");
  a_dat_upper: assert property (ack_o |-> dat_o[31:8] == 24'h0) else $error("read data upper bits set");
  a_reset_quiet: assert property ($fell(rst_i) |-> backplane_out_o == 3'h0
    && !ladder_fast_o && !ladder_weak_o && bias_tenths_o == 9'h006) else $error("outputs not idle after reset");
  a_bias_table: assert property ($stable(contrast_code_o) [*2] |->
    bias_tenths_o == bias_lut[contrast_code_o]) else $error("bias level does not match code");
  a_ladder_excl: assert property (!(ladder_weak_o && ladder_fast_o))
    else $error("weak and fast ladder at once");
  a_bp_onehot: assert property ($onehot0(backplane_out_o)) else $error("several backplanes active");
  a_shared_bp: assert property (shared_pin_is_backplane_o && shared_plane_pin_o |-> backplane_out_o == 3'h0)
    else $error("shared backplane overlaps another");
  a_base_hold: assert property ($rose(segment_base_clock_o) |-> segment_base_clock_o [*8])
    else $error("base clock half too short");
  a_fast_hold: assert property ($rose(ladder_fast_o) |-> ladder_fast_o [*4])
    else $error("fast pulse too short");
endmodule
bind seg_lcd_timing seg_lcd_timing_asserts chk_u (.*);

// ---- panel_model.sv ----
// Panel model: records which backplanes the block has energised
`timescale 1ns/100ps
module panel_model
(
  input wire clk_i,
  input wire clear_i,
  input wire [2:0] backplane_i,
  input wire shared_pin_i,
  input wire shared_is_bp_i,
  output logic [3:0] seen_o
);
  always @(posedge clk_i)
  begin
    if (clear_i)
      seen_o <= 4'h0;
    else
      seen_o <= seen_o | {shared_is_bp_i & shared_pin_i, backplane_i};
  end
endmodule

// ---- tb_seg_lcd_timing.sv ----
// Self-checking bench for the segment display timing block
`timescale 1ns/100ps
module tb_seg_lcd_timing;
  logic clk_i, rst_i, cyc_i, stb_i, we_i, crystal_ref_clock, clr;
  logic [31:0] adr_i, dat_i, rd, lf;
  logic [3:0] sel_i;
  logic [2:0] xc;
  logic [7:0] dm [14];
  wire [31:0] dat_o;
  wire ack_o, shared_plane_pin_o, shared_pin_is_backplane_o, plane_polarity_o, segment_base_clock_o;
  wire ladder_weak_o, ladder_fast_o;
  wire [2:0] backplane_out_o;
  wire [26:1] frontplane_out_o;
  wire [3:0] contrast_code_o, seen;
  wire [8:0] bias_tenths_o;
  int err_total, n_tests, n, w;
  seg_lcd_timing dut_u (.*);
  panel_model pm_u (.clk_i(clk_i), .clear_i(clr), .backplane_i(backplane_out_o), .shared_pin_i(shared_plane_pin_o),
    .shared_is_bp_i(shared_pin_is_backplane_o), .seen_o(seen));
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // Expected segment bit for frontplane fp and backplane bp
  function automatic logic seg_exp(input int fp, input int bp);
    return dm[fp / 2][(fp % 2) * 4 + bp];
  endfunction
  initial
  begin
    clk_i = 0;
    forever #5 clk_i = ~clk_i;
  end
  // Crystal reference: one rising edge every 8 clocks
  always @(posedge clk_i)
  begin
    xc <= xc + 3'h1;
    crystal_ref_clock <= xc[2];
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] %0t got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic wr, input logic [7:0] idx, input logic [7:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= wr;
    adr_i <= {22'h0, idx, 2'h0};
    dat_i <= {24'h0, d};
    do
      @(posedge clk_i);
    while (ack_o !== 1'b1);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask
  // Length in clocks of the next high stretch of base clock or fast pulse
  task automatic hi_width(input bit fast);
    w = 0;
    n = 0;
    while ((fast ? ladder_fast_o : segment_base_clock_o) !== 1'b0 && n < 3000)
    begin
      @(posedge clk_i);
      n++;
    end
    while ((fast ? ladder_fast_o : segment_base_clock_o) !== 1'b1 && n < 6000)
    begin
      @(posedge clk_i);
      n++;
    end
    while ((fast ? ladder_fast_o : segment_base_clock_o) === 1'b1 && w < 3000)
    begin
      @(posedge clk_i);
      w++;
    end
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Watchdog: whole run needs about 15500 clocks
  initial
  begin
    #400000;
    err_total++;
    final_report;
  end
  initial
  begin
    {xc, crystal_ref_clock, cyc_i, stb_i, we_i, adr_i, dat_i} = 0;
    clr = 1;
    sel_i = 4'hF;
    lf = 32'hF73DF5CA;
    rst_i = 1;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(0, 8'h4E, 0);
    chk(rd, 0);
    wb(0, 8'h4F, 0);
    chk(rd, 0);
    wb(1, 8'h51, 8'hFF);
    wb(0, 8'h51, 0);
    chk(rd, 0);
    sel_i <= 4'hE;
    wb(1, 8'h4E, 8'h2F);
    sel_i <= 4'hF;
    wb(0, 8'h4E, 0);
    chk(rd, 0);
    for (int i = 0; i < 6; i++)
    begin
      lf = lfsr(lf);
      wb(1, 8'h4E, lf[7:0] & 8'h6F);
      wb(1, 8'h4F, lf[15:8]);
      wb(0, 8'h4E, 0);
      chk(rd, {24'h0, lf[7:0] & 8'h6F});
      wb(0, 8'h4F, 0);
      chk(rd, {24'h0, lf[15:8] & 8'h7F});
      repeat (3) @(posedge clk_i);
      chk(contrast_code_o, lf[3:0]);
    end
    $display("test registers done");
    for (int k = 0; k < 14; k++)
    begin
      lf = lfsr(lf);
      dm[k] = lf[7:0];
      wb(1, 8'h52 + k[7:0], dm[k]);
    end
    wb(1, 8'h4F, 8'h08);
    wb(1, 8'h4E, 8'h80);
    clr <= 1'b0;
    hi_width(0);
    chk(w, 512);
    for (n = 0; n < 4000 && backplane_out_o !== 3'h2; n++)
      @(posedge clk_i);
    chk(backplane_out_o, 3'h2);
    chk(frontplane_out_o[1], seg_exp(1, 1));
    chk(frontplane_out_o[26], seg_exp(26, 1));
    chk(shared_plane_pin_o, seg_exp(0, 1));
    chk(plane_polarity_o, segment_base_clock_o);
    wb(0, 8'h50, 0);
    chk(rd & 32'h0F, 32'h03);
    clr <= 1'b1;
    @(posedge clk_i);
    clr <= 1'b0;
    repeat (3100) @(posedge clk_i);
    chk(seen, 4'h7);
    $display("test third duty done");
    wb(1, 8'h4F, 8'h10);
    chk(shared_pin_is_backplane_o, 0);
    repeat (3200) @(posedge clk_i);
    clr <= 1'b1;
    @(posedge clk_i);
    clr <= 1'b0;
    repeat (4200) @(posedge clk_i);
    chk(seen, 4'hF);
    chk(shared_pin_is_backplane_o, 1);
    $display("test quarter duty done");
    wb(1, 8'h4E, 8'hE0);
    for (int l = 0; l < 3; l++)
    begin
      wb(1, 8'h4F, {1'b0, l[1:0], 5'h00});
      hi_width(1);
      chk(w, 32 >> l);
      chk(ladder_weak_o, 1);
    end
    $display("test fast charge done");
    wb(1, 8'h4F, 8'h07);
    repeat (4) @(posedge clk_i);
    chk({backplane_out_o, segment_base_clock_o, plane_polarity_o}, 0);
    wb(1, 8'h4F, 8'h01);
    hi_width(0);
    chk(w, 1024);
    wb(1, 8'h4E, 0);
    repeat (4) @(posedge clk_i);
    chk({ladder_weak_o, ladder_fast_o, frontplane_out_o}, 0);
    $display("test stop done");
    final_report;
  end
endmodule
